// ---- hw/tlic_pkg.sv ----
// Shared constants for the two-level interrupt controller and its core end
package tlic_pkg;
    localparam int unsigned NUM_SRC = 13;
    localparam logic [7:0] REG_IE_SEC = 8'hA7;
    localparam logic [7:0] REG_IE_MAIN = 8'hA8;
    localparam logic [7:0] REG_IP_SEC = 8'hB7;
    localparam logic [7:0] REG_IP_MAIN = 8'hB8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int unsigned GLOBAL_EN_BIT = 7;
    localparam logic [7:0] MAIN_MASK = 8'h7F;
    localparam logic [7:0] SEC_MASK = 8'hF2;
    localparam int unsigned VEC_W = 16;
    // Source index = polling position
    localparam int unsigned SRC_DEBUG = 0;
    localparam int unsigned SRC_EXTA = 1;
    localparam int unsigned SRC_TMRA = 2;
    localparam int unsigned SRC_EXTB = 3;
    localparam int unsigned SRC_TMRB = 4;
    localparam int unsigned SRC_UART0 = 5;
    localparam int unsigned SRC_TMRC = 6;
    localparam int unsigned SRC_SPI = 7;
    localparam int unsigned SRC_RSVD = 8;
    localparam int unsigned SRC_TWOWIRE = 9;
    localparam int unsigned SRC_ADC = 10;
    localparam int unsigned SRC_PCA = 11;
    localparam int unsigned SRC_UART1 = 12;
    localparam logic [VEC_W-1:0] VECTORS [NUM_SRC] = '{
        16'h0063, 16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
        16'h002B, 16'h0053, 16'h0033, 16'h0043, 16'h003B, 16'h005B,
        16'h004B};
    // Enable/priority bit of each source: bit 3 selects secondary register
    localparam logic [3:0] SRC_BIT [NUM_SRC] = '{
        4'h6, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hE, 4'h8,
        4'h9, 4'hF, 4'hD, 4'hC};
    localparam int unsigned PCA_CAUSES = 8;
    localparam int unsigned SPI_CAUSES = 4;
endpackage

// ---- hw/tlic_link_if.sv ----
// Interface joining the interrupt controller and the core end
`timescale 1ns/1ps
interface tlic_link_if;
    logic                            reqValid;
    logic [tlic_pkg::VEC_W-1:0]      reqVector;
    logic [3:0]                      reqSource;
    logic                            reqHigh;
    logic                            vectorAck;
    logic                            retiPulse;
    logic                            idleEnter;
    logic                            idleActive;
    logic                            sfrWr;
    logic                            sfrRd;
    logic [7:0]                      sfrAddr;
    logic [7:0]                      sfrWdata;
    logic [7:0]                      sfrRdata;
    modport ctrl (
        output reqValid, reqVector, reqSource, reqHigh, idleActive, sfrRdata,
        input  vectorAck, retiPulse, idleEnter, sfrWr, sfrRd, sfrAddr,
        sfrWdata
    );
    modport core (
        input  reqValid, reqVector, reqSource, reqHigh, idleActive, sfrRdata,
        output vectorAck, retiPulse, idleEnter, sfrWr, sfrRd, sfrAddr,
        sfrWdata
    );
endinterface

// ---- hw/tlic_controller.sv ----
// Interrupt controller: flags, enables, priorities, arbitration, nesting
`timescale 1ns/1ps
module tlic_controller (
    input  wire logic       clk,
    input  wire logic       rst_b,
    tlic_link_if.ctrl       link,
    input  wire logic       extIrqPinA,
    input  wire logic       extIrqPinB,
    input  wire logic       extATriggerType,
    input  wire logic       extBTriggerType,
    input  wire logic       timerAOverflowSet,
    input  wire logic       timerASplitMode,
    input  wire logic       timerBOverflowSet,
    input  wire logic       timerCOverflowFlag,
    input  wire logic       timerCExternalFlag,
    input  wire logic       timerCExternalEnable,
    input  wire logic       twowireIrqSet,
    input  wire logic       adcIrqFlag,
    input  wire logic       adcIrqEnable,
    input  wire logic [7:0] counterArrayCauses,
    input  wire logic [3:0] spiCauses,
    input  wire logic [3:0] spiCauseEnables,
    input  wire logic       uart0Flags,
    input  wire logic       uart1Flags,
    input  wire logic       debugBreakFlag,
    output logic            extARequestFlag,
    output logic            extBRequestFlag,
    output logic            timerAOverflowFlag,
    output logic            timerBOverflowFlag,
    output logic            twowireIrqFlag
);
    localparam int N = tlic_pkg::NUM_SRC;

    logic [7:0]   ieMain_q, ieSec_q, ipMain_q, ipSec_q;
    logic         extAFlag_q, extBFlag_q, pinA_q, pinB_q;
    logic         tmrA_q, tmrB_q, twowire_q;
    logic [1:0]   inService_q;   // [1]=high level, [0]=low level
    logic         idle_q;
    logic [7:0]   rdata_q;
    logic [N-1:0] pending, enabled, prio;
    logic [N-1:0] eligible;
    logic [3:0]   winIdx;
    logic         winFound;
    logic         ackA, ackB, ackTA, ackTB, ackTw;

    function automatic logic regBit(input logic [3:0] pos,
                                    input logic [7:0] mainR,
                                    input logic [7:0] secR);
        regBit = pos[3] ? secR[pos[2:0]] : mainR[pos[2:0]];
    endfunction

    // Register file
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ieMain_q <= tlic_pkg::REG_RESET;
            ieSec_q  <= tlic_pkg::REG_RESET;
            ipMain_q <= tlic_pkg::REG_RESET;
            ipSec_q  <= tlic_pkg::REG_RESET;
        end else if (link.sfrWr) begin
            unique case (link.sfrAddr)
                tlic_pkg::REG_IE_MAIN: ieMain_q <= link.sfrWdata;
                tlic_pkg::REG_IE_SEC:  ieSec_q  <= link.sfrWdata
                                                  & tlic_pkg::SEC_MASK;
                // Unused priority bits read as zero
                tlic_pkg::REG_IP_MAIN: ipMain_q <= link.sfrWdata
                                                  & tlic_pkg::MAIN_MASK;
                tlic_pkg::REG_IP_SEC:  ipSec_q  <= link.sfrWdata
                                                  & tlic_pkg::SEC_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (link.sfrRd) begin
            unique case (link.sfrAddr)
                tlic_pkg::REG_IE_MAIN: rdata_q <= ieMain_q;
                tlic_pkg::REG_IE_SEC:  rdata_q <= ieSec_q;
                tlic_pkg::REG_IP_MAIN: rdata_q <= ipMain_q;
                tlic_pkg::REG_IP_SEC:  rdata_q <= ipSec_q;
                default:               rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign link.sfrRdata = rdata_q;

    // Vector-time clears, only when that source is the one taken
    always_comb begin
        ackA  = link.vectorAck && winIdx == 4'(tlic_pkg::SRC_EXTA);
        ackB  = link.vectorAck && winIdx == 4'(tlic_pkg::SRC_EXTB);
        ackTA = link.vectorAck && winIdx == 4'(tlic_pkg::SRC_TMRA);
        ackTB = link.vectorAck && winIdx == 4'(tlic_pkg::SRC_TMRB);
        ackTw = link.vectorAck && winIdx == 4'(tlic_pkg::SRC_TWOWIRE);
    end

    // External pins are active low, as on the classic core
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinA_q <= 1'b1;
            pinB_q <= 1'b1;
        end else begin
            pinA_q <= extIrqPinA;
            pinB_q <= extIrqPinB;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            extAFlag_q <= 1'b0;
        end else if (!extATriggerType) begin
            extAFlag_q <= !extIrqPinA;
        end else if (pinA_q && !extIrqPinA) begin
            extAFlag_q <= 1'b1;
        end else if (ackA) begin
            extAFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            extBFlag_q <= 1'b0;
        end else if (!extBTriggerType) begin
            extBFlag_q <= !extIrqPinB;
        end else if (pinB_q && !extIrqPinB) begin
            extBFlag_q <= 1'b1;
        end else if (ackB) begin
            extBFlag_q <= 1'b0;
        end
    end

    // Set wins over the service clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tmrA_q    <= 1'b0;
            tmrB_q    <= 1'b0;
            twowire_q <= 1'b0;
        end else begin
            if (timerAOverflowSet && !timerASplitMode) tmrA_q <= 1'b1;
            else if (ackTA) tmrA_q <= 1'b0;
            if (timerBOverflowSet) tmrB_q <= 1'b1;
            else if (ackTB) tmrB_q <= 1'b0;
            if (twowireIrqSet) twowire_q <= 1'b1;
            else if (ackTw) twowire_q <= 1'b0;
        end
    end

    always_comb begin
        pending = '0;
        pending[tlic_pkg::SRC_DEBUG] = debugBreakFlag;
        pending[tlic_pkg::SRC_EXTA]  = extAFlag_q;
        pending[tlic_pkg::SRC_TMRA]  = tmrA_q;
        pending[tlic_pkg::SRC_EXTB]  = extBFlag_q;
        pending[tlic_pkg::SRC_TMRB]  = tmrB_q;
        pending[tlic_pkg::SRC_UART0] = uart0Flags;
        pending[tlic_pkg::SRC_TMRC]  = timerCOverflowFlag
            || (timerCExternalFlag && timerCExternalEnable);
        pending[tlic_pkg::SRC_SPI]   = |(spiCauses & spiCauseEnables);
        pending[tlic_pkg::SRC_TWOWIRE] = twowire_q;
        pending[tlic_pkg::SRC_ADC]   = adcIrqFlag && adcIrqEnable;
        pending[tlic_pkg::SRC_PCA]   = |counterArrayCauses;
        pending[tlic_pkg::SRC_UART1] = uart1Flags;
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gSrc
            assign enabled[g] = regBit(tlic_pkg::SRC_BIT[g], ieMain_q,
                                       ieSec_q);
            assign prio[g] = regBit(tlic_pkg::SRC_BIT[g], ipMain_q,
                                    ipSec_q);
            assign eligible[g] = pending[g] && enabled[g]
                && ieMain_q[tlic_pkg::GLOBAL_EN_BIT]
                && !inService_q[1] && (prio[g] || !inService_q[0]);
        end
    endgenerate

    // High level first, then polling order
    always_comb begin
        winIdx = 4'h0;
        winFound = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (!winFound && eligible[i] && prio[i]) begin
                winIdx = 4'(i);
                winFound = 1'b1;
            end
        end
        for (int i = 0; i < N; i++) begin
            if (!winFound && eligible[i]) begin
                winIdx = 4'(i);
                winFound = 1'b1;
            end
        end
    end

    assign link.reqValid  = winFound;
    assign link.reqSource = winIdx;
    assign link.reqVector = tlic_pkg::VECTORS[winIdx];
    assign link.reqHigh   = prio[winIdx];

    // Nesting: a low handler may be preempted, a high one may not
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            inService_q <= 2'b00;
        end else if (link.vectorAck && winFound) begin
            if (prio[winIdx]) inService_q[1] <= 1'b1;
            else inService_q[0] <= 1'b1;
        end else if (link.retiPulse) begin
            if (inService_q[1]) inService_q[1] <= 1'b0;
            else inService_q[0] <= 1'b0;
        end
    end

    // Idle ends on any enabled, globally allowed request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idle_q <= 1'b0;
        end else if (|(pending & enabled)
                     && ieMain_q[tlic_pkg::GLOBAL_EN_BIT]) begin
            idle_q <= 1'b0;
        end else if (link.idleEnter) begin
            idle_q <= 1'b1;
        end
    end
    assign link.idleActive = idle_q;

    assign extARequestFlag    = extAFlag_q;
    assign extBRequestFlag    = extBFlag_q;
    assign timerAOverflowFlag = tmrA_q;
    assign timerBOverflowFlag = tmrB_q;
    assign twowireIrqFlag     = twowire_q;
endmodule

// ---- hw/tlic_core_end.sv ----
// Core end: takes requests, acknowledges vectors, forwards register access
`timescale 1ns/1ps
module tlic_core_end (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    tlic_link_if.core                       link,
    input  wire logic                       takeEnable,
    input  wire logic                       handlerDone,
    input  wire logic                       enterIdle,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    input  wire logic [7:0]                 regAddr,
    input  wire logic [7:0]                 regWdata,
    output logic      [7:0]                 regRdata,
    output logic      [tlic_pkg::VEC_W-1:0] vectorTaken,
    output logic                            vectorStrobe,
    output logic                            idle
);
    logic [tlic_pkg::VEC_W-1:0] vec_q;
    logic                       strobe_q;

    // Handlers must deassert level sources before signalling done
    assign link.vectorAck = link.reqValid && takeEnable;
    assign link.retiPulse = handlerDone;
    assign link.idleEnter = enterIdle;
    assign link.sfrWr     = regWr;
    assign link.sfrRd     = regRd;
    assign link.sfrAddr   = regAddr;
    assign link.sfrWdata  = regWdata;
    assign regRdata       = link.sfrRdata;
    assign idle           = link.idleActive;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vec_q    <= '0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= link.vectorAck;
            if (link.vectorAck) vec_q <= link.reqVector;
        end
    end
    assign vectorTaken  = vec_q;
    assign vectorStrobe = strobe_q;
endmodule

// ---- test/tlic_link_props.sv ----
// Assertions watching the link between the controller and the core end
`timescale 1ns/1ps
module tlic_link_props (
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire logic                       reqValid,
    input wire logic [tlic_pkg::VEC_W-1:0] reqVector,
    input wire logic [3:0]                 reqSource,
    input wire logic                       reqHigh,
    input wire logic                       vectorAck,
    input wire logic                       retiPulse,
    input wire logic                       idleActive,
    input wire logic                       sfrWr,
    input wire logic                       sfrRd,
    input wire logic [7:0]                 sfrAddr,
    input wire logic [7:0]                 sfrWdata,
    input wire logic [7:0]                 sfrRdata
);
    logic hiBusy_q;
    logic loBusy_q;
    // Shadow of the in-service levels; a return retires the high level first
    // An acknowledge beats a return landing in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) hiBusy_q <= 1'b0;
        else if (vectorAck && reqHigh) hiBusy_q <= 1'b1;
        else if (retiPulse && !vectorAck) hiBusy_q <= 1'b0;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) loBusy_q <= 1'b0;
        else if (vectorAck && !reqHigh) loBusy_q <= 1'b1;
        else if (retiPulse && !hiBusy_q && !vectorAck) loBusy_q <= 1'b0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence wrMain; sfrWr && sfrAddr == tlic_pkg::REG_IE_MAIN; endsequence
    sequence rdMain; sfrRd && sfrAddr == tlic_pkg::REG_IE_MAIN; endsequence
    vec_map_a: assert property (reqValid |->
        reqVector == tlic_pkg::VECTORS[reqSource]) else $error("bad vector");
    src_legal_a: assert property (reqValid |->
        reqSource < 4'hD && reqSource != 4'h8) else $error("bad source");
    high_lock_a: assert property (hiBusy_q |-> !reqValid)
        else $error("request while high level in service");
    low_lock_a: assert property (loBusy_q && reqValid |-> reqHigh)
        else $error("low request while low level in service");
    ack_legal_a: assert property (vectorAck |-> reqValid)
        else $error("acknowledge without request");
    rd_quiet_a: assert property (!$past(sfrRd) |-> sfrRdata == 8'h00)
        else $error("read data outside read cycle");
    rd_mask_a: assert property (sfrRd && (sfrAddr == 8'hA7 ||
        sfrAddr == 8'hB7) |=> (sfrRdata & ~tlic_pkg::SEC_MASK) == 8'h00)
        else $error("unused secondary bit reads set");
    wr_read_a: assert property (wrMain ##1 rdMain |=>
        sfrRdata == $past(sfrWdata, 2)) else $error("write not read back");
    idle_wake_a: assert property (idleActive && reqValid |=>
        !idleActive) else $error("idle kept with request");
endmodule

// ---- test/tb_top.sv ----
// Bench joining the controller and core end, driving both user sides
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] REGS [4] = '{8'hA7, 8'hA8, 8'hB7, 8'hB8};
    localparam logic [7:0] MSKS [4] = '{8'hF2, 8'hFF, 8'hF2, 8'h7F};
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        extIrqPinA, extIrqPinB, extATriggerType, extBTriggerType;
    logic        timerAOverflowSet, timerASplitMode, timerBOverflowSet;
    logic        timerCOverflowFlag, timerCExternalFlag, timerCExternalEnable;
    logic        twowireIrqSet, adcIrqFlag, adcIrqEnable, uart0Flags;
    logic        uart1Flags, debugBreakFlag, takeEnable, handlerDone;
    logic        enterIdle, regWr, regRd, vectorStrobe, idle;
    logic        extARequestFlag, extBRequestFlag, timerAOverflowFlag;
    logic        timerBOverflowFlag, twowireIrqFlag;
    logic [7:0]  counterArrayCauses, regAddr, regWdata, regRdata;
    logic [3:0]  spiCauses, spiCauseEnables;
    logic [15:0] vectorTaken;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    tlic_link_if link ();
    tlic_controller i_tlic_controller (.clk, .rst_b, .link(link),
        .extIrqPinA, .extIrqPinB, .extATriggerType, .extBTriggerType,
        .timerAOverflowSet, .timerASplitMode, .timerBOverflowSet,
        .timerCOverflowFlag, .timerCExternalFlag, .timerCExternalEnable,
        .twowireIrqSet, .adcIrqFlag, .adcIrqEnable, .counterArrayCauses,
        .spiCauses, .spiCauseEnables, .uart0Flags, .uart1Flags,
        .debugBreakFlag, .extARequestFlag, .extBRequestFlag,
        .timerAOverflowFlag, .timerBOverflowFlag, .twowireIrqFlag);
    tlic_core_end i_tlic_core_end (.clk, .rst_b, .link(link), .takeEnable,
        .handlerDone, .enterIdle, .regWr, .regRd, .regAddr, .regWdata,
        .regRdata, .vectorTaken, .vectorStrobe, .idle);
    tlic_link_props i_tlic_link_props (.clk, .rst_b,
        .reqValid(link.reqValid), .reqVector(link.reqVector),
        .reqSource(link.reqSource), .reqHigh(link.reqHigh),
        .vectorAck(link.vectorAck), .retiPulse(link.retiPulse),
        .idleActive(link.idleActive), .sfrWr(link.sfrWr),
        .sfrRd(link.sfrRd), .sfrAddr(link.sfrAddr),
        .sfrWdata(link.sfrWdata), .sfrRdata(link.sfrRdata));
    always #25 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Whole run needs a few hundred cycles; the ceiling only cuts a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chkVal({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chkVal({8'h00, regRdata}, {8'h00, e});
    endtask
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] e);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        rd(a, e);
    endtask
    // Bit index of each source in the {secondary, main} register pair
    function automatic logic [15:0] bitsFor(input logic [12:0] m);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 13; i++) if (m[i]) r[tlic_pkg::SRC_BIT[i]] = 1'b1;
        return r;
    endfunction
    task automatic setEn(input logic [12:0] m, input logic g);
        logic [15:0] e;
        e = bitsFor(m);
        wrrd(8'hA8, {g, e[6:0]}, {g, e[6:0]});
        wrrd(8'hA7, e[15:8], e[15:8] & 8'hF2);
    endtask
    task automatic setPri(input logic [12:0] m);
        logic [15:0] e;
        e = bitsFor(m);
        wrrd(8'hB8, e[7:0], e[7:0]);
        wrrd(8'hB7, e[15:8], e[15:8] & 8'hF2);
    endtask
    task automatic ack(input logic [15:0] e);
        @(posedge clk);
        takeEnable <= 1'b1;
        @(posedge clk);
        takeEnable <= 1'b0;
        #1;
        for (int k = 0; k < 6 && vectorStrobe !== 1'b1; k++) tick(1);
        chkBit(vectorStrobe, 1'b1);
        chkVal(vectorTaken, e);
    endtask
    task automatic retire();
        @(posedge clk);
        handlerDone <= 1'b1;
        @(posedge clk);
        handlerDone <= 1'b0;
    endtask
    initial begin
        int j;
        logic [3:0] s;
        {extIrqPinA, extIrqPinB, extBTriggerType} = 3'b111;
        {extATriggerType, timerAOverflowSet, timerASplitMode, enterIdle,
         timerBOverflowSet, timerCOverflowFlag, timerCExternalFlag, regRd,
         timerCExternalEnable, twowireIrqSet, adcIrqFlag, adcIrqEnable, regWr,
         uart0Flags, uart1Flags, debugBreakFlag, takeEnable, handlerDone} = '0;
        {counterArrayCauses, spiCauses, spiCauseEnables, regAddr} = '0;
        regWdata = 8'h00;
        j = $urandom(59184);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) rd(REGS[i], 8'h00);
        for (int i = 0; i < 4; i++) wrrd(REGS[i], 8'hFF, MSKS[i]);
        wrrd(8'hA9, 8'h5A, 8'h00);
        repeat (4) setEn(13'($urandom), 1'($urandom));
        setPri(13'h0000);
        @(posedge clk);
        {extIrqPinA, extIrqPinB} <= 2'b00;
        {debugBreakFlag, uart0Flags, uart1Flags} <= 3'b111;
        {timerCOverflowFlag, adcIrqFlag, adcIrqEnable} <= 3'b111;
        {timerAOverflowSet, timerBOverflowSet, twowireIrqSet} <= 3'b111;
        counterArrayCauses <= 8'h01 << $urandom_range(7, 0);
        s = 4'h1 << $urandom_range(3, 0);
        spiCauses <= s;
        spiCauseEnables <= s;
        @(posedge clk);
        {timerAOverflowSet, timerBOverflowSet, twowireIrqSet} <= 3'b000;
        tick(2);
        chkBit(extARequestFlag, 1'b1);
        chkBit(extBRequestFlag, 1'b1);
        chkBit(twowireIrqFlag, 1'b1);
        for (int k = 0; k < 13; k++) begin
            setEn(13'h1FFF << k, 1'b1);
            tick(1);
            j = (k == 8) ? 9 : k;
            chkBit(link.reqValid, 1'b1);
            chkVal(link.reqVector, tlic_pkg::VECTORS[j]);
        end
        setEn(13'h1FFF, 1'b0);
        tick(1);
        chkBit(link.reqValid, 1'b0);
        @(posedge clk);
        {timerCOverflowFlag, timerCExternalFlag, adcIrqEnable} <= 3'b010;
        setEn(13'h0440, 1'b1);
        tick(1);
        chkBit(link.reqValid, 1'b0);
        @(posedge clk);
        timerCExternalEnable <= 1'b1;
        tick(1);
        chkVal(link.reqVector, 16'h002B);
        @(posedge clk);
        {timerCExternalFlag, adcIrqEnable} <= 2'b01;
        tick(1);
        chkVal(link.reqVector, 16'h003B);
        @(posedge clk);
        timerCOverflowFlag <= 1'b1;
        setEn(13'h1FFF, 1'b1);
        repeat (4) begin
            j = $urandom_range(12, 0);
            j = (j == 8) ? 12 : j;
            setPri(13'h0001 << j);
            tick(1);
            chkBit(link.reqHigh, 1'b1);
            chkVal(link.reqVector, tlic_pkg::VECTORS[j]);
        end
        setPri(13'h0000);
        ack(16'h0063);
        tick(1);
        chkBit(link.reqValid, 1'b0);
        setPri(13'h000E);
        tick(1);
        chkVal(link.reqVector, 16'h0003);
        ack(16'h0003);
        tick(1);
        chkBit(extARequestFlag, 1'b1);
        chkBit(link.reqValid, 1'b0);
        retire();
        tick(1);
        chkVal(link.reqVector, 16'h0003);
        @(posedge clk);
        extIrqPinA <= 1'b1;
        tick(2);
        chkBit(extARequestFlag, 1'b0);
        ack(16'h000B);
        tick(1);
        chkBit(timerAOverflowFlag, 1'b0);
        retire();
        ack(16'h0013);
        tick(1);
        chkBit(extBRequestFlag, 1'b0);
        retire();
        tick(1);
        chkBit(link.reqValid, 1'b0);
        retire();
        tick(1);
        chkVal(link.reqVector, 16'h0063);
        @(posedge clk);
        debugBreakFlag <= 1'b0;
        timerASplitMode <= 1'b1;
        timerAOverflowSet <= 1'b1;
        @(posedge clk);
        timerAOverflowSet <= 1'b0;
        ack(16'h001B);
        tick(1);
        chkBit(timerBOverflowFlag, 1'b0);
        chkBit(timerAOverflowFlag, 1'b0);
        retire();
        setEn(13'h0000, 1'b1);
        @(posedge clk);
        enterIdle <= 1'b1;
        @(posedge clk);
        enterIdle <= 1'b0;
        tick(2);
        chkBit(idle, 1'b1);
        setEn(13'h0020, 1'b1);
        tick(2);
        chkBit(idle, 1'b0);
        stop_test();
    end
endmodule
